// ===== src/traj_cmd_pkg.sv
// Constants and types for the trajectory command and status logic
package traj_cmd_pkg;
  // Command codes
  localparam logic [7:0] START_MOTION_CODE    = 8'h01;
  localparam logic [7:0] LOAD_TRAJECTORY_CODE = 8'h1f;
  localparam logic [7:0] CLEAR_INTERRUPTS_CODE = 8'h1d;
  localparam logic [7:0] RESET_CODE           = 8'h00;
  localparam logic [7:0] INDEX_CAPTURE_CODE   = 8'h03;
  localparam logic [7:0] ERROR_LIMIT_STOP_CODE = 8'h1b;
  localparam logic [7:0] ERROR_LIMIT_IRQ_CODE = 8'h1c;
  // Control word field positions
  localparam int CW_POS_REL   = 0;
  localparam int CW_POS_LOAD  = 1;
  localparam int CW_VEL_REL   = 2;
  localparam int CW_VEL_LOAD  = 3;
  localparam int CW_ACC_REL   = 4;
  localparam int CW_ACC_LOAD  = 5;
  localparam int CW_STOP_OFF  = 8;
  localparam int CW_STOP_ABR  = 9;
  localparam int CW_STOP_SMO  = 10;
  localparam int CW_VEL_MODE  = 11;
  localparam int CW_FORWARD   = 12;
  // Status byte bit positions
  localparam int ST_BUSY      = 0;
  localparam int ST_CMD_ERR   = 1;
  localparam int ST_TRAJ_DONE = 2;
  localparam int ST_INDEX     = 3;
  localparam int ST_WRAP      = 4;
  localparam int ST_POS_ERR   = 5;
  localparam int ST_BREAKPT   = 6;
  localparam int ST_MOTOR_OFF = 7;
  // Reset values and codes
  localparam logic [7:0]  STATUS_RESET    = 8'h80;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam logic [31:0] PARAM_RESET     = 32'h0000_0000;
  localparam logic [11:0] ZERO_DRIVE_CODE = 12'h800;
  // Range limits
  localparam logic [31:0] POS_MAX = 32'h3fff_ffff;
  localparam logic [31:0] POS_MIN = 32'hc000_0000;
  localparam logic [31:0] MAG_MAX = 32'h3fff_ffff;
  // Busy time after each command byte and each completed data byte pair, in cycles
  localparam logic [3:0]  BUSY_CYCLES = 4'h4;
  // Parameter word sequence slot: 2 words each, 1 word for the control word
  typedef enum logic [6:0] {
    SEQ_IDLE = 7'b0000001,
    SEQ_CW   = 7'b0000010,
    SEQ_ACC  = 7'b0000100,
    SEQ_VEL  = 7'b0001000,
    SEQ_POS  = 7'b0010000,
    SEQ_READ = 7'b0100000,
    SEQ_DONE = 7'b1000000
  } seq_t;
endpackage

// ===== src/traj_start_status.sv
// Trajectory load, start and status logic behind the host byte port
`timescale 1ns/1ps
`default_nettype none
module traj_start_status
  import traj_cmd_pkg::*;
(
  input  wire logic        REF_CLK,          // 25 MHz clock
  input  wire logic        RST,              // Synchronous, active high
  input  wire logic        CS_N,             // Device select
  input  wire logic        PORT_SELECT_N,    // Low: command/status port
  input  wire logic        RD_N,             // Read strobe
  input  wire logic        WR_N,             // Write strobe
  input  wire logic [7:0]  DATA_IN,          // Host write data
  output logic      [7:0]  DATA_OUT,         // Host read data
  output logic             DATA_OE_N,        // Low while driving the bus
  input  wire logic        BREAKPOINT_HIT,   // Breakpoint exceeded pulse
  input  wire logic        POS_ERROR_HIT,    // Error threshold exceeded pulse
  input  wire logic        WRAP_HIT,         // Position overflow pulse
  input  wire logic        INDEX_PULSE,      // Encoder index pulse
  input  wire logic        ON_TARGET,        // Profile generator finished
  input  wire logic [31:0] PRESENT_POS,      // Current position
  output logic      [31:0] WORK_ACC,         // Working acceleration
  output logic      [31:0] WORK_VEL,         // Working velocity
  output logic      [31:0] WORK_POS,         // Working target position
  output logic      [5:0]  WORK_FLAGS,       // Load/relative flags applied
  output logic             VEL_MODE,         // Working velocity mode
  output logic             FORWARD_DIR,      // Working direction
  output logic             SMOOTH_STOP,      // Decelerate at programmed rate
  output logic             START_PULSE,      // One cycle per accepted start
  output logic      [11:0] MOTOR_DRIVE_CODE, // Zero drive while off
  output logic             MOTOR_OFF         // Motor output is off
);

  // Host strobes, taken as synchronous; edges found by delaying one cycle
  logic       rd_d_r;                 // Previous read strobe level
  logic       wr_d_r;                 // Previous write strobe level
  logic       rd_now;                 // Read active this cycle
  logic       wr_now;                 // Write active this cycle
  logic       rd_fall;                // Start of a read
  logic       wr_fall;                // Start of a write
  logic [3:0] busy_cnt_r;             // Busy countdown
  logic       busy;                   // Busy status bit
  logic [7:0] flags_r;                // Sticky status bits 7..1
  logic [15:0] ctrl_buf_r;            // Primary control word
  logic [31:0] acc_buf_r;             // Primary acceleration
  logic [31:0] vel_buf_r;             // Primary velocity
  logic [31:0] pos_buf_r;             // Primary position
  logic       acc_changed_r;          // Acceleration loaded, not started
  logic       moving_r;               // Trajectory in progress
  logic       index_armed_r;          // Index capture armed
  logic       stop_on_err_r;          // Error-limit stop armed
  seq_t       seq_r;                  // Parameter load sequence
  logic [1:0] byte_cnt_r;             // Byte index inside a 32-bit item
  logic [7:0] hi_r;                   // Held control word high byte
  logic [23:0] acc_word_r;            // Assembled bytes of current item
  logic       start_ok;               // Legal start this cycle
  logic       start_bad;              // Illegal start this cycle
  logic       cmd_wr;                 // Command byte accepted
  logic       data_wr;                // Data byte accepted
  logic       data_rd;                // Data read accepted
  logic       clr_irq;                // Clear interrupts command
  logic       soft_rst;               // Reset command
  logic       wrong_dir;              // Transfer opposite to expectation
  logic [31:0] item;                  // Completed 32-bit item
  logic       item_done;              // Last byte of an item written

  assign rd_now   = !CS_N && !RD_N;
  assign wr_now   = !CS_N && !WR_N;
  assign rd_fall  = rd_now && !rd_d_r;
  assign wr_fall  = wr_now && !wr_d_r;
  assign busy     = (busy_cnt_r != 4'h0);
  // Writes while busy simply vanish and raise no error
  assign cmd_wr   = wr_fall && !PORT_SELECT_N && !busy;
  assign data_wr  = wr_fall && PORT_SELECT_N && !busy && seq_r != SEQ_IDLE
                    && seq_r != SEQ_READ;
  assign data_rd  = rd_fall && PORT_SELECT_N && !busy;
  // Reading data with nothing to read, or writing data with no load open
  assign wrong_dir = (data_rd && seq_r != SEQ_READ)
                   || (wr_fall && PORT_SELECT_N && !busy
                       && (seq_r == SEQ_IDLE || seq_r == SEQ_READ));
  // A start mid-move after new acceleration is refused
  assign start_bad = cmd_wr && DATA_IN == START_MOTION_CODE
                   && moving_r && acc_changed_r;
  assign start_ok  = cmd_wr && DATA_IN == START_MOTION_CODE && !start_bad;
  assign clr_irq   = cmd_wr && DATA_IN == CLEAR_INTERRUPTS_CODE;
  assign soft_rst  = cmd_wr && DATA_IN == RESET_CODE;
  assign item      = {acc_word_r, DATA_IN};
  assign item_done = data_wr && byte_cnt_r == 2'd3;

  // Strobe history
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rd_d_r <= 1'b0;
      wr_d_r <= 1'b0;
    end else begin
      rd_d_r <= rd_now;
      wr_d_r <= wr_now;
    end
  end

  // Busy after each command byte and each completed byte pair
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      busy_cnt_r <= 4'h0;
    end else if (cmd_wr || (data_wr && byte_cnt_r[0])) begin
      busy_cnt_r <= BUSY_CYCLES;
    end else if (busy) begin
      busy_cnt_r <= busy_cnt_r - 4'h1;
    end
  end

  // Load sequence: control word, then flagged items acc, vel, pos
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      seq_r      <= SEQ_IDLE;
      byte_cnt_r <= 2'd0;
      acc_word_r <= 24'h000000;
      hi_r       <= 8'h00;
    end else if (cmd_wr) begin
      byte_cnt_r <= 2'd0;
      seq_r      <= (DATA_IN == LOAD_TRAJECTORY_CODE) ? SEQ_CW : SEQ_IDLE;
    end else if (data_wr) begin
      acc_word_r <= {acc_word_r[15:0], DATA_IN};
      if (seq_r == SEQ_CW) begin
        // Control word: high byte first, then low byte
        if (byte_cnt_r == 2'd0) begin
          hi_r       <= DATA_IN;
          byte_cnt_r <= 2'd1;
        end else begin
          byte_cnt_r <= 2'd0;
          if (DATA_IN[CW_ACC_LOAD]) seq_r <= SEQ_ACC;
          else if (DATA_IN[CW_VEL_LOAD]) seq_r <= SEQ_VEL;
          else if (DATA_IN[CW_POS_LOAD]) seq_r <= SEQ_POS;
          else seq_r <= SEQ_IDLE;
        end
      end else begin
        byte_cnt_r <= byte_cnt_r + 2'd1;
        if (item_done) begin
          // Next flagged item, in descending order
          if (seq_r == SEQ_ACC && ctrl_buf_r[CW_VEL_LOAD]) seq_r <= SEQ_VEL;
          else if (seq_r != SEQ_POS && ctrl_buf_r[CW_POS_LOAD]) seq_r <= SEQ_POS;
          else seq_r <= SEQ_IDLE;
        end
      end
    end
  end

  // Primary buffers; working registers only change on a legal start
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_buf_r <= CTRL_RESET;
      acc_buf_r  <= PARAM_RESET;
      vel_buf_r  <= PARAM_RESET;
      pos_buf_r  <= PARAM_RESET;
    end else if (data_wr) begin
      if (seq_r == SEQ_CW && byte_cnt_r == 2'd1) ctrl_buf_r <= {hi_r, DATA_IN};
      // Only the low 30 bits of magnitude are kept for positive items
      if (item_done && seq_r == SEQ_ACC) acc_buf_r <= item & MAG_MAX;
      if (item_done && seq_r == SEQ_VEL) vel_buf_r <= item & MAG_MAX;
      if (item_done && seq_r == SEQ_POS) pos_buf_r <= item;
    end
  end

  // Working registers, copied at start
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      WORK_ACC    <= PARAM_RESET;
      WORK_VEL    <= PARAM_RESET;
      WORK_POS    <= PARAM_RESET;
      WORK_FLAGS  <= 6'h00;
      VEL_MODE    <= 1'b0;
      FORWARD_DIR <= 1'b0;
      SMOOTH_STOP <= 1'b0;
      START_PULSE <= 1'b0;
    end else begin
      START_PULSE <= start_ok;
      if (start_ok) begin
        WORK_ACC    <= acc_buf_r;
        WORK_VEL    <= vel_buf_r;
        WORK_FLAGS  <= ctrl_buf_r[5:0];
        VEL_MODE    <= ctrl_buf_r[CW_VEL_MODE];
        // Direction only matters in velocity mode
        FORWARD_DIR <= ctrl_buf_r[CW_VEL_MODE] & ctrl_buf_r[CW_FORWARD];
        SMOOTH_STOP <= ctrl_buf_r[CW_STOP_SMO];
        // Abrupt stop: target becomes where the motor is now
        if (ctrl_buf_r[CW_STOP_ABR]) WORK_POS <= PRESENT_POS;
        // An unflagged position keeps the previous target
        else if (ctrl_buf_r[CW_POS_LOAD] && ctrl_buf_r[CW_POS_REL]) WORK_POS <= WORK_POS + pos_buf_r;
        else if (ctrl_buf_r[CW_POS_LOAD]) WORK_POS <= pos_buf_r;
      end
    end
  end

  // Motion state, acceleration-changed and arming flags
  always_ff @(posedge REF_CLK) begin
    if (RST || soft_rst) begin
      moving_r      <= 1'b0;
      acc_changed_r <= 1'b0;
      index_armed_r <= 1'b0;
      stop_on_err_r <= 1'b0;
    end else begin
      if (start_ok) moving_r <= !ctrl_buf_r[CW_STOP_OFF] && !ctrl_buf_r[CW_STOP_ABR];
      else if (ON_TARGET || flags_r[ST_MOTOR_OFF]) moving_r <= 1'b0;
      // Set wins over the start that would clear it
      if (item_done && seq_r == SEQ_ACC) acc_changed_r <= 1'b1;
      else if (start_ok) acc_changed_r <= 1'b0;
      if (cmd_wr && DATA_IN == INDEX_CAPTURE_CODE) index_armed_r <= 1'b1;
      else if (INDEX_PULSE) index_armed_r <= 1'b0;
      if (cmd_wr && DATA_IN == ERROR_LIMIT_STOP_CODE) stop_on_err_r <= 1'b1;
      else if (cmd_wr && DATA_IN == ERROR_LIMIT_IRQ_CODE) stop_on_err_r <= 1'b0;
    end
  end

  // Sticky status flags; any set wins over a clear in the same cycle
  always_ff @(posedge REF_CLK) begin
    if (RST || soft_rst) begin
      flags_r <= STATUS_RESET;
    end else begin
      if (POS_ERROR_HIT && stop_on_err_r) flags_r[ST_MOTOR_OFF] <= 1'b1;
      else if (start_ok) flags_r[ST_MOTOR_OFF] <= ctrl_buf_r[CW_STOP_OFF];
      flags_r[ST_BREAKPT]   <= BREAKPOINT_HIT | (flags_r[ST_BREAKPT] & !clr_irq);
      flags_r[ST_POS_ERR]   <= POS_ERROR_HIT | (flags_r[ST_POS_ERR] & !clr_irq);
      flags_r[ST_WRAP]      <= WRAP_HIT | (flags_r[ST_WRAP] & !clr_irq);
      flags_r[ST_INDEX]     <= (INDEX_PULSE & index_armed_r)
                               | (flags_r[ST_INDEX] & !clr_irq);
      flags_r[ST_TRAJ_DONE] <= (flags_r[ST_MOTOR_OFF] | (ON_TARGET & !start_ok))
                               | (flags_r[ST_TRAJ_DONE] & !clr_irq);
      flags_r[ST_CMD_ERR]   <= start_bad | wrong_dir
                               | (flags_r[ST_CMD_ERR] & !clr_irq);
      flags_r[ST_BUSY]      <= 1'b0;
    end
  end

  // Host read port: status on port select low, otherwise stale buffer
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      DATA_OUT  <= STATUS_RESET;
      DATA_OE_N <= 1'b1;
    end else begin
      DATA_OE_N <= !rd_now;
      if (rd_now && !PORT_SELECT_N) begin
        DATA_OUT <= {flags_r[7:1], busy};
      end
      // Data reads keep the last buffer contents; nothing here is readable
    end
  end

  // Motor drive output
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      MOTOR_DRIVE_CODE <= ZERO_DRIVE_CODE;
      MOTOR_OFF        <= 1'b1;
    end else begin
      MOTOR_OFF        <= flags_r[ST_MOTOR_OFF];
      if (flags_r[ST_MOTOR_OFF]) MOTOR_DRIVE_CODE <= ZERO_DRIVE_CODE;
    end
  end

  // Checks
  a_start_copies: assert property (@(posedge REF_CLK) disable iff (RST)
    start_ok |=> START_PULSE && WORK_ACC == $past(acc_buf_r)) else $error("start copy");
  a_bad_start_err: assert property (@(posedge REF_CLK) disable iff (RST)
    start_bad |=> flags_r[ST_CMD_ERR] && !START_PULSE) else $error("bad start");
  a_busy_ignores: assert property (@(posedge REF_CLK) disable iff (RST)
    busy && wr_fall |=> $stable(ctrl_buf_r) && !START_PULSE) else $error("busy write");
  a_flag_sticky: assert property (@(posedge REF_CLK) disable iff (RST)
    flags_r[ST_WRAP] && !clr_irq && !soft_rst |=> flags_r[ST_WRAP]) else $error("sticky");
  a_wrap_sets: assert property (@(posedge REF_CLK) disable iff (RST)
    WRAP_HIT |=> flags_r[ST_WRAP]) else $error("wrap");
  a_status_read: assert property (@(posedge REF_CLK) disable iff (RST)
    rd_now && !PORT_SELECT_N |=> !DATA_OE_N && DATA_OUT[7:1] == $past(flags_r[7:1])) else $error("status");
  a_busy_len: assert property (@(posedge REF_CLK) disable iff (RST)
    cmd_wr |=> busy [*4] ##1 !busy) else $error("busy len");
  a_dir_mode: assert property (@(posedge REF_CLK) disable iff (RST)
    FORWARD_DIR |-> VEL_MODE) else $error("dir");
  a_off_drive: assert property (@(posedge REF_CLK) disable iff (RST)
    MOTOR_OFF |=> MOTOR_DRIVE_CODE == ZERO_DRIVE_CODE) else $error("drive");
  c_start: cover property (@(posedge REF_CLK) start_ok);
  c_bad_start: cover property (@(posedge REF_CLK) start_bad);
  c_pos_item: cover property (@(posedge REF_CLK) item_done && seq_r == SEQ_POS);
endmodule
`default_nettype wire

// ===== verif/host_port_model.sv
// Host processor model for the byte-wide command, status and data port
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  input  wire logic       REF_CLK,       // Port clock
  output logic            CS_N,          // Device select
  output logic            PORT_SELECT_N, // Low: command or status
  output logic            RD_N,          // Read strobe
  output logic            WR_N,          // Write strobe
  output logic      [7:0] DATA_IN,       // Byte to the device
  input  wire logic [7:0] DATA_OUT,      // Byte from the device
  input  wire logic       DATA_OE_N      // Low while the device drives
);
  logic oe_seen; // Output enable seen with the last answer
  // Idle port: nothing selected, both strobes high
  initial begin
    CS_N = 1'b1;
    PORT_SELECT_N = 1'b1;
    RD_N = 1'b1;
    WR_N = 1'b1;
    DATA_IN = 8'h00;
    oe_seen = 1'b1;
  end
  // One strobe: taken at the first edge, answered at the second, then released
  task automatic xfer(input logic ps, input logic rd, input logic [7:0] d, output logic [7:0] q);
    @(posedge REF_CLK);
    CS_N <= 1'b0;
    PORT_SELECT_N <= ps;
    RD_N <= ~rd;
    WR_N <= rd;
    DATA_IN <= d;
    repeat (2) @(posedge REF_CLK);
    #1;
    q = DATA_OUT;
    oe_seen = DATA_OE_N;
    CS_N <= 1'b1;
    RD_N <= 1'b1;
    WR_N <= 1'b1;
    // A released bus must not look like the old byte
    DATA_IN <= ~d;
  endtask
  // Poll the status byte until busy drops; bounded so a stuck device ends the run
  task automatic ready(output logic [7:0] s);
    s = 8'hff;
    for (int i = 0; i < 16 && s[0] !== 1'b0; i++) xfer(1'b0, 1'b1, 8'h00, s);
    if (s[0] !== 1'b0) tb.timeout_hit();
  endtask
  // Write one byte; poll afterwards unless the caller means to hit busy
  task automatic put(input logic ps, input logic [7:0] d, input logic poll);
    logic [7:0] s;
    xfer(ps, 1'b0, d, s);
    if (poll) ready(s);
  endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the trajectory load, start and status logic
`timescale 1ns/1ps
`default_nettype none
module tb;
  import traj_cmd_pkg::*;
  logic        clk, rst, on_tgt;                 // Clock, reset, profile done
  logic [3:0]  ev;                               // Breakpoint, error, wrap, index
  logic [31:0] pres;                             // Present position
  wire logic   cs_n, ps_n, rd_n, wr_n, oe_n, vm, fwd, smo, stp, moff;
  wire logic [7:0]  din, dout;
  wire logic [31:0] wacc, wvel, wpos;
  wire logic [5:0]  wfl;
  wire logic [11:0] drive;
  int failures, comparisons, starts, nst, seed;
  logic [7:0]  est;                              // Expected status flags
  logic [15:0] lcw, wcw;                         // Loaded and working control words
  logic [31:0] bacc, bvel, bpos, macc, mvel, mpos, r;
  traj_start_status dut (.REF_CLK(clk), .RST(rst), .CS_N(cs_n), .PORT_SELECT_N(ps_n), .RD_N(rd_n),
    .WR_N(wr_n), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N(oe_n), .BREAKPOINT_HIT(ev[3]),
    .POS_ERROR_HIT(ev[2]), .WRAP_HIT(ev[1]), .INDEX_PULSE(ev[0]), .ON_TARGET(on_tgt), .PRESENT_POS(pres),
    .WORK_ACC(wacc), .WORK_VEL(wvel), .WORK_POS(wpos), .WORK_FLAGS(wfl), .VEL_MODE(vm), .FORWARD_DIR(fwd),
    .SMOOTH_STOP(smo), .START_PULSE(stp), .MOTOR_DRIVE_CODE(drive), .MOTOR_OFF(moff));
  host_port_model host (.REF_CLK(clk), .CS_N(cs_n), .PORT_SELECT_N(ps_n), .RD_N(rd_n), .WR_N(wr_n),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N(oe_n));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Count start pulses; each must be exactly one cycle wide
  always @(posedge clk) if (stp === 1'b1) starts++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic timeout_hit;
    failures++;
    results();
  endtask
  task automatic stat(input logic [7:0] e);
    logic [7:0] s;
    host.ready(s);
    chk(s, e);
    chk(host.oe_seen, 1'b0);
  endtask
  // Load command, control word, then flagged parameters as 4 bytes each, MSB first
  task automatic load(input logic [15:0] cw, input logic [31:0] a, input logic [31:0] v, input logic [31:0] p);
    logic [31:0] w[$];
    lcw = cw;
    host.put(1'b0, LOAD_TRAJECTORY_CODE, 1'b1);
    host.put(1'b1, cw[15:8], 1'b1);
    host.put(1'b1, cw[7:0], 1'b1);
    if (cw[CW_ACC_LOAD]) w.push_back(a);
    if (cw[CW_VEL_LOAD]) w.push_back(v);
    if (cw[CW_POS_LOAD]) w.push_back(p);
    foreach (w[i]) for (int b = 3; b >= 0; b--) host.put(1'b1, w[i][8*b +: 8], 1'b1);
    if (cw[CW_ACC_LOAD]) bacc = a;
    if (cw[CW_VEL_LOAD]) bvel = v;
    if (cw[CW_POS_LOAD]) bpos = p;
  endtask
  // Accepted start: copy buffers to working values in the model and compare
  task automatic go;
    host.put(1'b0, START_MOTION_CODE, 1'b1);
    nst++;
    wcw = lcw;
    macc = bacc;
    mvel = bvel;
    if (wcw[CW_POS_LOAD]) mpos = wcw[CW_POS_REL] ? mpos + bpos : bpos;
    if (wcw[CW_STOP_ABR]) mpos = pres;
    est[ST_MOTOR_OFF] = wcw[CW_STOP_OFF];
    est[ST_TRAJ_DONE] = est[ST_TRAJ_DONE] | est[ST_MOTOR_OFF];
    chk(starts, nst);
    chk(wacc, macc);
    chk(wvel, mvel);
    chk(wpos, mpos);
    chk({moff, vm, smo, wfl}, {est[7], wcw[11], wcw[10], wcw[5:0]});
    if (wcw[CW_VEL_MODE]) chk(fwd, wcw[CW_FORWARD]);
    if (est[ST_MOTOR_OFF]) chk(drive, ZERO_DRIVE_CODE);
    stat(est);
  endtask
  task automatic clr;
    host.put(1'b0, CLEAR_INTERRUPTS_CODE, 1'b1);
    est[6:1] = 6'h00;
    est[ST_TRAJ_DONE] = est[ST_MOTOR_OFF];
    stat(est);
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
  endtask
  initial begin
    logic [7:0] s;
    seed = 61661;
    rst = 1'b1;
    on_tgt = 1'b0;
    ev = 4'h0;
    pres = 32'h0;
    {bacc, bvel, bpos, macc, mvel, mpos} = '0;
    est = 8'h84;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({drive, moff, oe_n}, {ZERO_DRIVE_CODE, 1'b1, 1'b1});
    chk(wpos, 32'h0);
    stat(est);
    // Full load in velocity mode; working values wait for the start
    r = $random(seed) & 32'h1fff_ffff;
    load(16'h182a, r, r + ($random(seed) & 32'h0000_ffff), {{2{r[29]}}, r[29:0]});
    chk({wacc, moff}, {32'h0, 1'b1});
    go();
    clr();
    // Relative position during motion is allowed without an acceleration change
    r = $random(seed) & 32'h0000_ffff;
    load(16'h0003, 32'h0, 32'h0, r);
    go();
    // Acceleration changed mid-move: start refused, a write while busy is ignored
    load(16'h0020, mvel >> 1, 32'h0, 32'h0);
    host.put(1'b0, START_MOTION_CODE, 1'b0);
    host.put(1'b0, CLEAR_INTERRUPTS_CODE, 1'b1);
    est[ST_CMD_ERR] = 1'b1;
    stat(est);
    chk({starts, wacc}, {nst, macc});
    @(posedge clk);
    on_tgt <= 1'b1;
    est[ST_TRAJ_DONE] = 1'b1;
    go();
    @(posedge clk);
    on_tgt <= 1'b0;
    clr();
    // Data transfers with no load open are wrong-direction accesses
    host.put(1'b1, 8'h55, 1'b1);
    est[ST_CMD_ERR] = 1'b1;
    stat(est);
    clr();
    host.xfer(1'b1, 1'b1, 8'h00, s);
    est[ST_CMD_ERR] = 1'b1;
    stat(est);
    clr();
    // Each manual stop alone, one bit per control word; motor off last
    for (int i = 10; i >= 8; i--) begin
      @(posedge clk);
      pres <= $random(seed);
      load(16'h0001 << i, 32'h0, 32'h0, 32'h0);
      chk(moff, est[ST_MOTOR_OFF]);
      go();
    end
    // Event flags; index only counts once capture is armed
    clr();
    pulse(4'he);
    pulse(4'h1);
    est[6:4] = 3'h7;
    stat(est);
    host.put(1'b0, INDEX_CAPTURE_CODE, 1'b1);
    pulse(4'h1);
    est[ST_INDEX] = 1'b1;
    stat(est);
    clr();
    // Armed error stop turns the motor off; the reset command restores power-up flags
    load(16'h0000, 32'h0, 32'h0, 32'h0);
    go();
    host.put(1'b0, ERROR_LIMIT_STOP_CODE, 1'b1);
    pulse(4'h4);
    est[ST_MOTOR_OFF] = 1'b1;
    est[ST_POS_ERR] = 1'b1;
    est[ST_TRAJ_DONE] = 1'b1;
    stat(est);
    host.put(1'b0, RESET_CODE, 1'b1);
    est = 8'h84;
    stat(est);
    results();
  end
endmodule
`default_nettype wire
